// File: src/dlsm_delay_timer.sv
`timescale 1ns/1ps
module dlsm_delay_timer #(
  parameter int CW = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic tick_i,
  input wire logic cond_i,
  input wire logic [CW-1:0] limit_i,
  output logic expired_o
);

  logic [CW-1:0] cnt;

  // ==========================================================
  // Tick counter, saturating so a long violation never wraps
  // ==========================================================
  // RULE19: restart on clear
  always_ff @(posedge clk_i) begin
    if (rst_i || !cond_i) begin
      cnt <= '0;
    end else if (tick_i && (cnt != {CW{1'b1}})) begin
      cnt <= cnt + 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      expired_o <= 1'b0;
    end else begin
      expired_o <= cond_i && (cnt >= limit_i);
    end
  end

  // ==========================================================
  // Checks
  // ==========================================================
  timer_restart_a: assert property ( // RULE19
    @(posedge clk_i) disable iff (rst_i)
    !cond_i |=> (cnt == '0) && !expired_o
  ) else $error("delay timer did not restart after condition cleared");

  timer_early_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    $rose(expired_o) |-> $past(cond_i) && ($past(cnt) >= $past(limit_i))
  ) else $error("delay timer expired before its limit");

endmodule

// File: src/dlsm_pkg.sv
package dlsm_pkg;

  // ==========================================================
  // Data widths and clock
  // ==========================================================
  localparam int DW = 16;
  localparam int WB_AW = 8;
  localparam int WB_DW = 32;
  localparam int IDX_W = WB_AW - 2;
  localparam int DI_N = 4;
  localparam int SEL_W = 8;
  localparam int CLK_FREQ_HZ = 100_000_000;
  localparam int HZ_PER_MHZ = 1_000_000;

  // ==========================================================
  // Timing: delay registers count in ticks of one millisecond
  // ==========================================================
  localparam int TICK_TIME_US = 1000;
  localparam int TICK_CYCLES = CLK_FREQ_HZ / HZ_PER_MHZ * TICK_TIME_US;
  localparam int STALL_DELAY_US = 10_000;
  localparam int LOAD_DELAY_US = 10_000_000;
  localparam int STALL_DELAY_TICKS = STALL_DELAY_US / TICK_TIME_US;
  localparam int LOAD_DELAY_TICKS = LOAD_DELAY_US / TICK_TIME_US;
  localparam int STALL_THR_PERCENT = 5;

  // ==========================================================
  // Configuration registers, word index = byte address / 4
  // ==========================================================
  localparam int CFG_N = 15;
  localparam int C_CONFIG = 0;
  localparam int C_RESPONSE = 1;
  localparam int C_INSEL = 2;
  localparam int C_STALL_THR = 3;
  localparam int C_STALL_DLY = 4;
  localparam int C_LOAD_DLY = 5;
  localparam int C_SPD1 = 6;
  localparam int C_SPD2 = 7;
  localparam int C_SPD3 = 8;
  localparam int C_TU1 = 9;
  localparam int C_TL1 = 10;
  localparam int C_TU2 = 11;
  localparam int C_TL2 = 12;
  localparam int C_TU3 = 13;
  localparam int C_TL3 = 14;
  localparam logic [IDX_W-1:0] R_STATUS2 = 6'h0F;
  localparam logic [IDX_W-1:0] R_EVENT = 6'h10;
  localparam logic [IDX_W-1:0] R_MASK = 6'h11;
  localparam logic [IDX_W-1:0] R_FAULT_ACK = 6'h12;

  localparam logic [DW-1:0] CFG_RESET [CFG_N] = '{
    16'h0001, 16'h0000, 16'h0000, DW'(STALL_THR_PERCENT),
    DW'(STALL_DELAY_TICKS), DW'(LOAD_DELAY_TICKS),
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
    16'h0000, 16'h0000, 16'h0000, 16'h0000};
  localparam logic [DW-1:0] CFG_MASK [CFG_N] = '{
    16'h0007, 16'h000F, 16'h00FF, 16'hFFFF, 16'hFFFF,
    16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF,
    16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF};

  // ==========================================================
  // Modes, responses, monitors
  // ==========================================================
  typedef enum logic [2:0] {
    DLSM_OFF = 3'h0,
    DLSM_TORQUE = 3'h1,
    DLSM_LOADF = 3'h3,
    DLSM_PUMP = 3'h4,
    DLSM_FAN = 3'h5
  } dlsm_mode_t;

  localparam logic [3:0] RESP_OFF = 4'h0;
  localparam logic [3:0] RESP_A_LOW = 4'h1;
  localparam logic [3:0] RESP_A_HIGH = 4'h2;
  localparam logic [3:0] RESP_A_TOL = 4'h3;
  localparam logic [3:0] RESP_F_LOW = 4'h4;
  localparam logic [3:0] RESP_F_HIGH = 4'h5;
  localparam logic [3:0] RESP_F_TOL = 4'h6;
  localparam logic [3:0] RESP_PF_ALARM = 4'h7;
  localparam logic [3:0] RESP_PF_FAULT = 4'h8;

  localparam int N_TMR = 6;
  localparam int T_STALL = 0;
  localparam int T_LOADF = 1;
  localparam int T_TRQ = 2;
  localparam int T_BLOCK = 3;
  localparam int T_LEAK = 4;
  localparam int T_DRY = 5;
  localparam int STALL_BIT = 7;

endpackage

// File: src/dlsm_top.sv
`timescale 1ns/1ps
// Contract
// RULE1: stall flag after error exceeds threshold long
// RULE2: stall threshold resets to five percent
// RULE3: stall delay resets to 0.01 seconds
// RULE4: operator may set threshold 100 to trace
// RULE5: load failure always gives a fault
// RULE6: torque deviation gives alarm or fault
// RULE7: config decodes off, torque, load, pump, fan
// RULE8: low load input too long gives fault
// RULE9: load monitoring delay resets to ten seconds
// RULE10: load input selectable, default constant one
// RULE11: envelope interpolated between three speed points
// RULE12: torque checked only between thresholds one, three
// RULE13: torque outside envelope too long triggers response
// RULE14: pump, fan supervise torque and speed in band
// RULE15: pump, fan regions too long trigger response
// RULE16: blockage both modes, leakage pump only
// RULE17: response decodes off, alarms, faults, pump/fan
// RULE18: pump, fan config only with response 7/8
// RULE19: delay timers restart when condition clears
module dlsm_top
  import dlsm_pkg::*;
#(
  parameter int TICK_CYCLES = dlsm_pkg::TICK_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [dlsm_pkg::WB_AW-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [dlsm_pkg::WB_DW-1:0] wb_dat_i,
  output logic [dlsm_pkg::WB_DW-1:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic motor_on_i,
  input wire logic [dlsm_pkg::DW-1:0] speed_i,
  input wire logic signed [dlsm_pkg::DW-1:0] torque_i,
  input wire logic [dlsm_pkg::DW-1:0] motor_model_error_i,
  input wire logic [dlsm_pkg::DI_N-1:0] digital_in_i,
  output logic stall_o,
  output logic alarm_o,
  output logic fault_o,
  output logic load_failure_fault_o,
  output logic irq_o
);
  import dlsm_pkg::*;

  localparam int DIV_W = $clog2(TICK_CYCLES);
  localparam int SW = DW + 2;
  localparam int PW = 2 * SW;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  logic [DW-1:0] cfg [CFG_N];
  logic [N_TMR-1:0] evt;
  logic [N_TMR-1:0] mask;
  logic [N_TMR-1:0] tmr_cond;
  logic [N_TMR-1:0] tmr_exp;
  logic [N_TMR-1:0] tmr_exp_q;
  logic [DI_N-1:0] di_meta;
  logic [DI_N-1:0] di_sync;
  logic [DIV_W-1:0] div_cnt;
  logic tick;
  logic [IDX_W-1:0] idx;
  logic req;
  logic wr_en;
  logic [DW-1:0] wr_lane;
  logic [DW-1:0] rd_word;
  logic [2:0] mode;
  logic [3:0] resp;
  logic load_present;
  logic band;
  logic seg2;
  logic too_low;
  logic too_high;
  logic pf_act;
  logic pf_hit;
  logic fault_set;
  logic fault_ack;
  logic lf_ack;

  // ==========================================================
  // Millisecond tick divider
  // ==========================================================
  always_ff @(posedge clk_i) begin
    if (rst_i || tick) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= div_cnt + 1'b1;
    end
  end

  assign tick = (div_cnt == DIV_W'(TICK_CYCLES - 1));

  // ==========================================================
  // Digital input synchroniser
  // ==========================================================
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      di_meta <= '0;
      di_sync <= '0;
    end else begin
      di_meta <= digital_in_i;
      di_sync <= di_meta;
    end
  end

  // ==========================================================
  // Wishbone slave
  // ==========================================================
  // Ack comes one cycle after the request; writes land on the
  // ack edge, when the master is known to still hold the data.
  assign idx = wb_adr_i[WB_AW-1:2];
  assign req = wb_cyc_i && wb_stb_i;
  assign wr_en = req && wb_we_i && wb_ack_o;

  always_comb begin
    wr_lane = wb_dat_i[DW-1:0];
    if (!wb_sel_i[0]) begin
      wr_lane[7:0] = rd_word[7:0];
    end
    if (!wb_sel_i[1]) begin
      wr_lane[15:8] = rd_word[15:8];
    end
  end

  always_comb begin
    rd_word = '0;
    for (int i = 0; i < CFG_N; i++) begin
      if (idx == IDX_W'(i)) begin
        rd_word = cfg[i];
      end
    end
    if (idx == R_STATUS2) begin
      rd_word[STALL_BIT] = stall_o;
    end
    if (idx == R_EVENT) begin
      rd_word[N_TMR-1:0] = evt;
    end
    if (idx == R_MASK) begin
      rd_word[N_TMR-1:0] = mask;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= req && !wb_ack_o;
      wb_dat_o <= {{(WB_DW - DW){1'b0}}, rd_word};
    end
  end

  // ==========================================================
  // Configuration registers
  // ==========================================================
  // RULE2: threshold reset value
  // RULE3: stall delay reset
  // RULE9: load delay reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < CFG_N; i++) begin
        cfg[i] <= CFG_RESET[i];
      end
    end else if (wr_en) begin
      for (int i = 0; i < CFG_N; i++) begin
        if (idx == IDX_W'(i)) begin
          cfg[i] <= wr_lane & CFG_MASK[i];
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask <= '0;
    end else if (wr_en && (idx == R_MASK)) begin
      mask <= wr_lane[N_TMR-1:0];
    end
  end

  assign fault_ack = wr_en && (idx == R_FAULT_ACK) && wr_lane[0];
  assign lf_ack = wr_en && (idx == R_FAULT_ACK) && wr_lane[1];

  // ==========================================================
  // Torque envelope
  // ==========================================================
  // Cross-multiplied line test: no divider, exact at any slope.
  // Returns sign of (t - line(x)) scaled by (xb - xa).
  function automatic logic [1:0] side_of(
    input logic signed [SW-1:0] t,
    input logic signed [SW-1:0] ya,
    input logic signed [SW-1:0] yb,
    input logic signed [SW-1:0] xa,
    input logic signed [SW-1:0] xb,
    input logic signed [SW-1:0] x
  );
    logic signed [PW-1:0] p;
    logic signed [PW-1:0] q;
    p = (t - ya) * (xb - xa);
    q = (yb - ya) * (x - xa);
    side_of = {p > q, p < q};
  endfunction

  function automatic logic signed [SW-1:0] sx(input logic [DW-1:0] v);
    sx = signed'({2'b00, v});
  endfunction

  function automatic logic signed [SW-1:0] st(input logic [DW-1:0] v);
    st = signed'({{2{v[DW-1]}}, v});
  endfunction

  assign mode = cfg[C_CONFIG][2:0];
  assign resp = cfg[C_RESPONSE][3:0];

  // RULE12: active band only
  assign band = (speed_i >= cfg[C_SPD1]) && (speed_i <= cfg[C_SPD3])
    && (cfg[C_SPD3] > cfg[C_SPD1]);
  assign seg2 = speed_i >= cfg[C_SPD2];

  // RULE11: interpolated limits
  always_comb begin
    logic [1:0] up;
    logic [1:0] lo;
    up = '0;
    lo = '0;
    if (seg2) begin
      up = side_of(st(torque_i), st(cfg[C_TU2]), st(cfg[C_TU3]),
        sx(cfg[C_SPD2]), sx(cfg[C_SPD3]), sx(speed_i));
      lo = side_of(st(torque_i), st(cfg[C_TL2]), st(cfg[C_TL3]),
        sx(cfg[C_SPD2]), sx(cfg[C_SPD3]), sx(speed_i));
    end else begin
      up = side_of(st(torque_i), st(cfg[C_TU1]), st(cfg[C_TU2]),
        sx(cfg[C_SPD1]), sx(cfg[C_SPD2]), sx(speed_i));
      lo = side_of(st(torque_i), st(cfg[C_TL1]), st(cfg[C_TL2]),
        sx(cfg[C_SPD1]), sx(cfg[C_SPD2]), sx(speed_i));
    end
    too_high = band && up[1];
    too_low = band && lo[0];
  end

  // ==========================================================
  // Monitor conditions
  // ==========================================================
  // RULE10: source select, zero means load present
  always_comb begin
    load_present = 1'b1;
    for (int i = 0; i < DI_N; i++) begin
      if (cfg[C_INSEL][SEL_W-1:0] == SEL_W'(i + 1)) begin
        load_present = di_sync[i];
      end
    end
  end

  // RULE14: pump and fan supervision
  assign pf_act = motor_on_i && band
    && ((mode == DLSM_PUMP) || (mode == DLSM_FAN))
    && ((resp == RESP_PF_ALARM) || (resp == RESP_PF_FAULT));

  always_comb begin
    tmr_cond = '0;
    // RULE1: error above threshold
    tmr_cond[T_STALL] = motor_on_i
      && (motor_model_error_i > cfg[C_STALL_THR]);
    // RULE8: load input low
    // RULE7: load failure in modes one and three
    tmr_cond[T_LOADF] = motor_on_i && !load_present
      && ((mode == DLSM_TORQUE) || (mode == DLSM_LOADF));
    // RULE13: envelope violation by response
    tmr_cond[T_TRQ] = motor_on_i && (mode == DLSM_TORQUE) && (
      (too_low && ((resp == RESP_A_LOW) || (resp == RESP_F_LOW)))
      || (too_high && ((resp == RESP_A_HIGH) || (resp == RESP_F_HIGH)))
      || ((too_low || too_high)
        && ((resp == RESP_A_TOL) || (resp == RESP_F_TOL))));
    // RULE16: blockage both modes, leakage pump only
    tmr_cond[T_BLOCK] = pf_act && too_low && !seg2;
    tmr_cond[T_LEAK] = pf_act && too_high && (mode == DLSM_PUMP);
    tmr_cond[T_DRY] = pf_act && too_low && seg2;
  end

  // ==========================================================
  // Delay timers
  // ==========================================================
  // RULE15: pump and fan regions share the load delay
  generate
    for (genvar g = 0; g < N_TMR; g++) begin : g_tmr
      dlsm_delay_timer #(
        .CW(DW)
      ) u_tmr (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .tick_i(tick),
        .cond_i(tmr_cond[g]),
        .limit_i((g == T_STALL) ? cfg[C_STALL_DLY] : cfg[C_LOAD_DLY]),
        .expired_o(tmr_exp[g])
      );
    end
  endgenerate

  // ==========================================================
  // Responses
  // ==========================================================
  assign pf_hit = tmr_exp[T_BLOCK] || tmr_exp[T_LEAK] || tmr_exp[T_DRY];

  // RULE5: load failure is always a fault
  // RULE6: alarm or fault per response
  // RULE17: response code decode
  assign fault_set = tmr_exp[T_LOADF]
    || (tmr_exp[T_TRQ] && (resp >= RESP_F_LOW) && (resp <= RESP_F_TOL))
    || (pf_hit && (resp == RESP_PF_FAULT));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stall_o <= 1'b0;
      alarm_o <= 1'b0;
    end else begin
      stall_o <= tmr_exp[T_STALL];
      alarm_o <= (tmr_exp[T_TRQ] && (resp >= RESP_A_LOW)
        && (resp <= RESP_A_TOL))
        || (pf_hit && (resp == RESP_PF_ALARM));
    end
  end

  // Faults latch until acknowledged; a new fault beats the ack.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fault_o <= 1'b0;
      load_failure_fault_o <= 1'b0;
    end else begin
      fault_o <= fault_set || (fault_o && !fault_ack);
      load_failure_fault_o <= tmr_exp[T_LOADF]
        || (load_failure_fault_o && !lf_ack);
    end
  end

  // ==========================================================
  // Events and interrupt
  // ==========================================================
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tmr_exp_q <= '0;
      evt <= '0;
      irq_o <= 1'b0;
    end else begin
      tmr_exp_q <= tmr_exp;
      evt <= (evt & ~((wr_en && (idx == R_EVENT))
        ? wr_lane[N_TMR-1:0] : '0)) | (tmr_exp & ~tmr_exp_q);
      irq_o <= |(evt & mask);
    end
  end

  // ==========================================================
  // Checks
  // ==========================================================
  stall_flag_clear_a: assert property ( // RULE1
    !tmr_cond[T_STALL] |-> ##2 !stall_o
  ) else $error("stall flag set without sustained error");

  stall_thr_reset_a: assert property ( // RULE2
    $fell(rst_i) |-> cfg[C_STALL_THR] == DW'(STALL_THR_PERCENT)
  ) else $error("stall threshold reset value wrong");

  stall_dly_reset_a: assert property ( // RULE3
    $fell(rst_i) |-> cfg[C_STALL_DLY] == DW'(STALL_DELAY_TICKS)
  ) else $error("stall delay reset value wrong");

  loadf_fault_a: assert property ( // RULE5
    tmr_exp[T_LOADF] |=> fault_o && load_failure_fault_o
  ) else $error("load failure did not raise fault");

  torque_alarm_a: assert property ( // RULE6
    tmr_exp[T_TRQ] && (resp == RESP_A_TOL) |=> alarm_o
  ) else $error("torque deviation alarm missing");

  mode_off_a: assert property ( // RULE7
    (mode == DLSM_OFF) |-> (tmr_cond[N_TMR-1:1] == '0)
  ) else $error("monitoring active while configuration off");

  load_dly_reset_a: assert property ( // RULE9
    $fell(rst_i) |-> (cfg[C_LOAD_DLY] == DW'(LOAD_DELAY_TICKS))
      && (cfg[C_INSEL] == '0)
  ) else $error("load delay or source reset value wrong");

  torque_band_a: assert property ( // RULE12
    (speed_i < cfg[C_SPD1]) || (speed_i > cfg[C_SPD3])
      |-> !tmr_cond[T_TRQ] && !pf_act
  ) else $error("torque checked outside speed band");

  leak_pump_a: assert property ( // RULE16
    (mode != DLSM_PUMP) |-> !tmr_cond[T_LEAK]
  ) else $error("leakage evaluated outside pump mode");

  irq_level_a: assert property (
    (evt & mask) != '0 |=> irq_o
  ) else $error("interrupt not raised for unmasked event");

endmodule

// File: verif/dlsm_motor_model.sv
`timescale 1ns/1ps
module dlsm_motor_model #(
  parameter logic [15:0] SLEW = 16'h0020
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic on_cmd_i,
  input wire logic [15:0] spd_cmd_i,
  input wire logic signed [15:0] trq_cmd_i,
  input wire logic [15:0] err_cmd_i,
  input wire logic load_ok_i,
  output logic motor_on_o,
  output logic [15:0] speed_o,
  output logic signed [15:0] torque_o,
  output logic [15:0] err_o,
  output logic [3:0] di_o
);
  // ==========================================================
  // Shaft and load
  // ==========================================================
  // Speed follows its command at a limited slew, so the band edges are
  // crossed gradually as on a real shaft, never jumped over
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      motor_on_o <= 1'b0;
      speed_o <= 16'h0000;
      torque_o <= 16'sh0000;
      err_o <= 16'h0000;
    end else begin
      motor_on_o <= on_cmd_i;
      torque_o <= trq_cmd_i;
      err_o <= err_cmd_i;
      if (speed_o + SLEW < spd_cmd_i) begin
        speed_o <= speed_o + SLEW;
      end else if (speed_o > spd_cmd_i + SLEW) begin
        speed_o <= speed_o - SLEW;
      end else begin
        speed_o <= spd_cmd_i;
      end
    end
  end

  // ==========================================================
  // Sense pins
  // ==========================================================
  // Unselected pins toggle so that no check can lean on a stale level
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      di_o <= 4'h1;
    end else begin
      di_o <= {~di_o[3:1], load_ok_i};
    end
  end
endmodule

// File: verif/drive_load_stall_monitor_tb_top.sv
`timescale 1ns/1ps
module drive_load_stall_monitor_tb_top;
  import dlsm_pkg::*;
  logic clk_i, rst_i, cyc, stb, we, ack, mon, on_c, ok_c;
  logic stall, alarm, fault, lff, irq;
  logic [WB_AW-1:0] adr;
  logic [3:0] sel;
  logic [WB_DW-1:0] dat_w, dat_r, rd;
  logic [DW-1:0] spd, err, spd_c, err_c;
  logic signed [DW-1:0] trq, trq_c;
  logic [DI_N-1:0] di;
  int fail_count, checks;
  int env [9] = '{100, 200, 300, 100, 0, 200, 50, 300, 100};
  // Columns: config, response, speed, torque, alarm, fault, event
  int pc [7][7] = '{'{4, 7, 150, 20, 1, 0, 8}, '{5, 7, 150, 20, 1, 0, 8},
    '{4, 7, 250, 260, 1, 0, 16}, '{5, 7, 250, 260, 0, 0, 0},
    '{5, 8, 250, 50, 0, 1, 32}, '{4, 8, 150, 20, 0, 1, 8},
    '{4, 7, 50, 20, 0, 0, 0}};

  dlsm_top #(.TICK_CYCLES(4)) uut (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack),
    .motor_on_i(mon), .speed_i(spd), .torque_i(trq),
    .motor_model_error_i(err), .digital_in_i(di), .stall_o(stall),
    .alarm_o(alarm), .fault_o(fault), .load_failure_fault_o(lff),
    .irq_o(irq));

  dlsm_motor_model model (.clk_i(clk_i), .rst_i(rst_i), .on_cmd_i(on_c),
    .spd_cmd_i(spd_c), .trq_cmd_i(trq_c), .err_cmd_i(err_c),
    .load_ok_i(ok_c), .motor_on_o(mon), .speed_o(spd), .torque_o(trq),
    .err_o(err), .di_o(di));

  // ==========================================================
  // Access tasks
  // ==========================================================
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Values read before this edge's updates land, so ack is the settled one
  task automatic wb(input logic w, input int a, input int d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= 8'(a);
    dat_w <= 32'(d);
    sel <= 4'hF;
    // No cycle budget here: only the watchdog may end a stuck wait
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    rd = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic rdchk(input int a, input int e);
    wb(1'b0, a, 0);
    chk(rd, 32'(e));
  endtask

  task automatic drv(input logic o, input int s, input int t, input int e,
                     input logic k);
    @(posedge clk_i);
    on_c <= o;
    spd_c <= 16'(s);
    trq_c <= 16'(t);
    err_c <= 16'(e);
    ok_c <= k;
  endtask

  task automatic tk(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  task automatic final_report();
    if (fail_count == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // ==========================================================
  // Clock, watchdog, sequence
  // ==========================================================
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // The sequence needs well under 20000 cycles; this is a hang
  initial begin
    #400_000;
    fail_count++;
    final_report();
  end

  initial begin
    int ea, ef;
    rst_i = 1'b1;
    {cyc, stb, we, on_c, ok_c} = 5'h01;
    adr = 8'h00;
    sel = 4'h0;
    dat_w = 32'h0;
    {spd_c, trq_c, err_c} = 48'h0;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    rdchk(8'h00, 1);
    rdchk(8'h04, 0);
    rdchk(8'h08, 0);
    rdchk(8'h0C, 5);
    rdchk(8'h10, 10);
    rdchk(8'h14, 10000);
    rdchk(8'hFC, 0);
    drv(1, 0, 0, 5, 1); tk(60); chk(stall, 0);
    drv(1, 0, 0, 6, 1); tk(32); chk(stall, 0);
    tk(20); chk(stall, 1);
    rdchk(8'h3C, 8'h80);
    rdchk(8'h40, 1);
    chk(irq, 0);
    wb(1, 8'h44, 1); tk(2); chk(irq, 1);
    wb(1, 8'h40, 1); tk(2); chk(irq, 0);
    drv(1, 0, 0, 0, 1); tk(4); chk(stall, 0);
    drv(1, 0, 0, 6, 1); tk(32); drv(1, 0, 0, 0, 1); tk(3);
    drv(1, 0, 0, 6, 1); tk(32); chk(stall, 0);
    wb(1, 8'h0C, 100); drv(1, 0, 0, 100, 1); tk(60); chk(stall, 0);
    drv(1, 0, 0, 101, 1); tk(60); chk(stall, 1);
    drv(1, 0, 0, 0, 1); wb(1, 8'h44, 0); wb(1, 8'h40, 8'h3F);
    wb(1, 8'h00, 3); wb(1, 8'h14, 2);
    drv(1, 0, 0, 0, 0); tk(30); chk(lff, 0);
    wb(1, 8'h08, 1); tk(30); chk(lff, 1);
    chk(fault, 1);
    rdchk(8'h40, 2);
    drv(1, 0, 0, 0, 1); tk(4); chk(lff, 1);
    wb(1, 8'h48, 3); tk(2); chk(lff, 0);
    wb(1, 8'h00, 0); drv(1, 0, 0, 0, 0); tk(30); chk(lff, 0);
    for (int i = 0; i < 9; i++) wb(1, 8'h18 + 4 * i, env[i]);
    wb(1, 8'h00, 1); drv(1, 150, 100, 0, 1); tk(20);
    for (int r = 0; r < 9; r++) begin
      for (int h = 0; h < 2; h++) begin
        ea = h ? (r == 2 || r == 3) : (r == 1 || r == 3);
        ef = h ? (r == 5 || r == 6) : (r == 4 || r == 6);
        wb(1, 8'h04, r); drv(1, 150, h ? 155 : 20, 0, 1); tk(30);
        chk(alarm, ea);
        chk(fault, ef);
        drv(1, 150, 100, 0, 1); tk(4); wb(1, 8'h48, 3);
      end
    end
    // Tolerance alarm, so the speed band, then the configuration mode, decides below
    wb(1, 8'h04, 3);
    drv(1, 50, 155, 0, 1); tk(40); chk(alarm, 0);
    drv(1, 100, 155, 0, 1); tk(40); chk(alarm, 1);
    drv(1, 350, 155, 0, 1); tk(40); chk(alarm, 0);
    wb(1, 8'h00, 3); drv(1, 150, 155, 0, 1); tk(40); chk(alarm, 0);
    for (int i = 0; i < 7; i++) begin
      wb(1, 8'h04, pc[i][1]); wb(1, 8'h00, pc[i][0]);
      drv(1, pc[i][2], 100, 0, 1); tk(20);
      wb(1, 8'h40, 8'h3F); wb(1, 8'h48, 3);
      drv(1, pc[i][2], pc[i][3], 0, 1); tk(30);
      chk(alarm, pc[i][4]);
      chk(fault, pc[i][5]);
      rdchk(8'h40, pc[i][6]);
      drv(1, pc[i][2], 100, 0, 1); tk(4);
    end
    final_report();
  end
endmodule
